/* File: design/pia_defs.vh */
// Constants for the priority interrupt arbiter: offsets, fields, resets, vectors
`ifndef PIA_DEFS_VH
`define PIA_DEFS_VH

// Sizes
`define PIA_NUM_CHAN      24
`define PIA_NUM_PAIR      12
`define PIA_NUM_EXT       8

// Register offsets (8-bit register port address)
`define PIA_OFF_CTRL      8'he6
`define PIA_OFF_EXT_EDGE  8'he7
`define PIA_OFF_EXTERNAL_MODE_REGISTER_TWO      8'he8
`define PIA_OFF_ISEG      8'he9
`define PIA_OFF_CSEG      8'hea
`define PIA_OFF_NEST      8'heb
`define PIA_OFF_PEND0     8'hec
`define PIA_OFF_PEND1     8'hed
`define PIA_OFF_PEND2     8'hee
`define PIA_OFF_STATUS    8'hef
`define PIA_OFF_LVL_BASE  8'hf0
`define PIA_OFF_VEC_BASE  8'hd0

// Central control and external mode register two fields
`define PIA_CTRL_CPL_LO   0
`define PIA_CTRL_CPL_HI   2
`define PIA_CTRL_IEN      4
`define PIA_CTRL_MODE     5
`define PIA_CTRL_TOP_LEVEL_UNMASKABLE     6
`define PIA_CTRL_TLSRC    7
`define PIA_EXTERNAL_MODE_REGISTER_TWO_ENSEG    0

// Reset values
`define PIA_CPL_RESET     3'h7
`define PIA_LVL_RESET     3'h7
`define PIA_VEC_RESET     6'h00
`define PIA_SEG_RESET     8'h00
`define PIA_EDGE_RESET    8'h00

// Fixed fetch locations
`define PIA_BOOT_ADDR     24'h000000
`define PIA_TL_VEC_OFS    16'h0004
`define PIA_DIV_VEC_OFS   16'h0002

`endif

/* File: design/pia_arbiter.v */
// Central priority interrupt arbiter with vectoring, nesting and segment save
`timescale 1ns/100ps
`include "pia_defs.vh"
// Notes on behaviour
// - Each channel has 3-bit level, 0 most urgent
// - Current priority is 3 bits, resets to 7
// - Every instruction, arbitrate all interrupt and transfer requests
// - Interrupt acknowledged only if level below current
// - Level 7 interrupt requests are never acknowledged
// - Top-level request beats every other request
// - Top-level routine uninterruptible; maskable or unmaskable
// - Top-level source: external pin or watchdog
// - Nested mode: same-level request never preempts same-level routine
// - Equal levels resolved by fixed chain order
// - Vector is software base plus hardware channel bit
// - Vector indexes 128-entry table in interrupt segment
// - After reset, start address fetched from zero
// - Top-level address fetched at fixed segment locations
// - Divide trap fetches from current code segment
// - Divide trap does not push the flags
// - Save disabled: interrupt segment replaces code segment
// - Save enabled: stack code segment, reload, restore
// - Compatible mode routines stay within one segment
// - Current priority software writable, hardware updated
// - Eight edge-programmable external inputs, standard group
// - Concurrent mode leaves current priority unchanged
// - Nested mode stacks priority bit, loads request level
// - Entry clears enable, pushes PC, segment (save enabled only), flags
// - Return pops, sets enable, nested restores priority

module pia_arbiter (
	// Clock and reset
	input  wire        i_clock,
	input  wire        i_rst_n,
	// Register port
	input  wire [7:0]  i_reg_addr,
	input  wire [7:0]  i_reg_wdata,
	input  wire        i_reg_write,
	input  wire        i_reg_read,
	output reg  [7:0]  o_reg_rdata,
	// Request sources, channel 0 is first in the chain
	input  wire [23:0] i_chan_req,
	input  wire [23:0] i_chan_dma,
	input  wire [7:0]  i_ext_pin,
	input  wire        i_nmi_pin,
	input  wire        i_wdt_top,
	// Core sequencer
	input  wire        i_arb_strobe,
	input  wire        i_div_zero,
	input  wire        i_iret,
	input  wire [7:0]  i_popped_seg,
	// Acknowledges
	output reg  [23:0] o_chan_ack,
	output reg  [23:0] o_dma_grant,
	output reg         o_top_ack,
	// Entry and return sequencing
	output reg         o_boot,
	output reg         o_entry,
	output reg  [23:0] o_fetch_addr,
	output reg  [7:0]  o_vector,
	output reg         o_push_seg,
	output reg         o_push_flags,
	output reg         o_pop_seg,
	output wire        o_use_iseg,
	output wire [7:0]  o_code_seg
);

	// Software-visible state
	reg  [2:0]  current_priority_level;                          // Current priority level
	reg         global_irq_enable;                          // Global interrupt enable
	reg         mode_nested;                  // Arbitration mode select
	reg         tl_unmaskable;                // Top level ignores enable
	reg         tl_src_wdt;                   // Top level from watchdog
	reg  [7:0]  ext_rising;                   // 1 rising, 0 falling edge
	reg         seg_save;                     // Segment save enable
	reg  [7:0]  iseg;                         // Interrupt segment
	reg  [7:0]  cseg;                         // Code segment
	reg  [7:0]  nest_stack;                   // Saved priority levels
	reg  [2:0]  level_reg [0:11];             // Level per channel pair
	reg  [5:0]  vbase_reg [0:11];             // Vector base per pair
	// Internal state
	reg  [7:0]  ext_prev;                     // Last sampled pins
	reg  [7:0]  ext_pend;                     // Latched external edges
	reg         tl_active;                    // In top-level routine
	reg         use_iseg;                     // Interrupt segment in use
	reg         boot_done;                    // Boot fetch issued
	// Arbitration results
	reg         win_ok;                       // Some channel is asking
	reg         win_dma;                      // Winner asks for a transfer
	reg  [4:0]  win_idx;                      // Winning channel index
	reg  [2:0]  win_lvl;                      // Winning channel level
	wire [23:0] int_req;
	wire [7:0]  ext_edge;
	wire        tl_req;
	wire        tl_take;
	wire        int_take;
	wire        dma_take;
	wire        div_take;
	wire [3:0]  pair;
	wire        wr_ctrl;                      // Control byte written
	wire [7:0]  ext_ack_clr;                  // Latch clears on acknowledge
	// Loop indices; each process owns its own so none has two drivers
	integer     k;                            // Arbitration walk
	integer     rst_i;                        // Bank reset walk

	// Index of the most recently saved level: lowest set bit
	// Deeper routines saved smaller levels, so they come back first
	function [2:0] lowest_set;
		input [7:0] bits;
		integer j;
		begin
			lowest_set = `PIA_CPL_RESET;
			for (j = 7; j >= 0; j = j - 1) begin
				if (bits[j]) begin
					lowest_set = j[2:0];
				end
			end
		end
	endfunction

	// Register offset decode for a bank of indexed registers
	// Twelve entries per bank, one for each channel pair
	function in_bank;
		input [7:0] addr;
		input [7:0] base;
		begin
			in_bank = (addr >= base) && (addr < base + 8'h0c);
		end
	endfunction

	// Edge detect on pins; polarity per input
	// Pins idle low after reset, so no false edge follows release
	assign ext_edge = (i_ext_pin & ~ext_prev & ext_rising) |
	                  (~i_ext_pin & ext_prev & ~ext_rising);
	// External edges share the first eight standard channels
	assign int_req  = i_chan_req | {16'h0000, ext_pend};
	// Top-level source selection
	assign tl_req   = tl_src_wdt ? i_wdt_top : i_nmi_pin;

	// Arbitration: least level wins, earlier chain position on ties
	always @* begin
		win_ok  = 1'b0;
		win_dma = 1'b0;
		win_idx = 5'h00;
		win_lvl = `PIA_CPL_RESET;
		// A channel asking for both is served as a transfer
		// Walk from last to first so the earlier channel wins a tie
		for (k = 23; k >= 0; k = k - 1) begin
			if ((int_req[k] || i_chan_dma[k]) &&
			    (!win_ok || level_reg[k / 2] <= win_lvl)) begin
				win_ok  = 1'b1;
				win_dma = i_chan_dma[k];
				win_idx = k[4:0];
				win_lvl = level_reg[k / 2];
			end
		end
	end

	// Top level overrides everything; its own routine is never cut
	assign tl_take  = i_arb_strobe && tl_req && !tl_active &&
	                  (tl_unmaskable || global_irq_enable);
	// Strict compare keeps level 7 and same-level requests out
	assign int_take = i_arb_strobe && !tl_take && !tl_active && win_ok &&
	                  !win_dma && global_irq_enable && (win_lvl < current_priority_level);
	// Transfer requests are served when they win the phase
	assign dma_take = i_arb_strobe && !tl_take && win_ok && win_dma;
	// Trap yields to the top level and to a taken interrupt
	assign div_take = i_div_zero && !tl_take && !int_take;
	// Channel pairs share one level and one vector register
	assign pair     = win_idx[4:1];
	// Control byte write decode
	assign wr_ctrl  = i_reg_write && (i_reg_addr == `PIA_OFF_CTRL);
	assign o_use_iseg = use_iseg;
	// Routines in compatible mode run from the interrupt segment only
	assign o_code_seg = use_iseg ? iseg : cseg;

	// Control register, priority and nesting stack
	always @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			current_priority_level           <= `PIA_CPL_RESET;
			global_irq_enable           <= 1'b0;
			mode_nested   <= 1'b0;
			tl_unmaskable <= 1'b0;
			tl_src_wdt    <= 1'b0;
			nest_stack    <= 8'h00;
		end else begin
			// Software may rewrite the control byte at any time
			if (wr_ctrl) begin
				current_priority_level           <= i_reg_wdata[`PIA_CTRL_CPL_HI:`PIA_CTRL_CPL_LO];
				global_irq_enable           <= i_reg_wdata[`PIA_CTRL_IEN];
				mode_nested   <= i_reg_wdata[`PIA_CTRL_MODE];
				tl_unmaskable <= i_reg_wdata[`PIA_CTRL_TOP_LEVEL_UNMASKABLE];
				tl_src_wdt    <= i_reg_wdata[`PIA_CTRL_TLSRC];
			end
			// Software may preload or clear the stack
			if (i_reg_write && i_reg_addr == `PIA_OFF_NEST) begin
				nest_stack <= i_reg_wdata;
			end
			// Hardware updates take precedence over a same-cycle write
			if (int_take) begin
				global_irq_enable <= 1'b0;
				if (mode_nested) begin
					nest_stack[current_priority_level] <= 1'b1;
					current_priority_level             <= win_lvl;
				end
			end else if (tl_take) begin
				// Top level keeps the priority as it was
				global_irq_enable <= 1'b0;
			end else if (i_iret) begin
				global_irq_enable <= 1'b1;
				// Top-level return leaves the priority as it was
				if (mode_nested && !tl_active && nest_stack != 8'h00) begin
					current_priority_level <= lowest_set(nest_stack);
					nest_stack[lowest_set(nest_stack)] <= 1'b0;
				end
			end
		end
	end

	// Other configuration registers and indexed banks
	always @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ext_rising <= `PIA_EDGE_RESET;
			seg_save   <= 1'b0;
			iseg       <= `PIA_SEG_RESET;
			for (rst_i = 0; rst_i < 12; rst_i = rst_i + 1) begin
				level_reg[rst_i] <= `PIA_LVL_RESET;
				vbase_reg[rst_i] <= `PIA_VEC_RESET;
			end
		end else if (i_reg_write) begin
			// Plain stores; no side effects
			case (i_reg_addr)
				`PIA_OFF_EXT_EDGE: begin
					ext_rising <= i_reg_wdata;
				end
				`PIA_OFF_EXTERNAL_MODE_REGISTER_TWO: begin
					seg_save <= i_reg_wdata[`PIA_EXTERNAL_MODE_REGISTER_TWO_ENSEG];
				end
				`PIA_OFF_ISEG: begin
					iseg <= i_reg_wdata;
				end
				// Writes past the bank ends are dropped
				default: begin
					if (in_bank(i_reg_addr, `PIA_OFF_LVL_BASE)) begin
						level_reg[i_reg_addr[3:0]] <= i_reg_wdata[2:0];
					end
					if (in_bank(i_reg_addr, `PIA_OFF_VEC_BASE)) begin
						vbase_reg[i_reg_addr[3:0]] <= i_reg_wdata[7:2];
					end
				end
			endcase
		end
	end

	// External pin edge latches; a new edge beats an acknowledge
	always @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ext_prev <= 8'h00;
			ext_pend <= 8'h00;
		end else begin
			ext_prev <= i_ext_pin;
			// An edge in the acknowledge cycle stays pending, never lost
			ext_pend <= (ext_pend & ~ext_ack_clr) | ext_edge;
		end
	end

	// Acknowledge of an external channel clears its latch
	// Peripheral channels drop their own request on the acknowledge
	assign ext_ack_clr = (int_take && win_idx < 5'd8) ?
	                     (8'h01 << win_idx[2:0]) : 8'h00;

	// Code segment, top-level and segment-mode tracking
	always @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cseg      <= `PIA_SEG_RESET;
			tl_active <= 1'b0;
			use_iseg  <= 1'b0;
		end else begin
			// With segment save enabled, entry or return below wins over a same-cycle software write
			if (i_reg_write && i_reg_addr == `PIA_OFF_CSEG) begin
				cseg <= i_reg_wdata;
			end
			if (tl_take || int_take) begin
				tl_active <= tl_take || tl_active;
				if (seg_save) begin
					cseg <= iseg;
				end else begin
					use_iseg <= 1'b1;
				end
			end else if (i_iret) begin
				// Limitation: a compatible return always drops the interrupt segment
				tl_active <= 1'b0;
				if (seg_save) begin
					cseg <= i_popped_seg;
				end else begin
					use_iseg <= 1'b0;
				end
			end
		end
	end

	// Entry outputs: one-cycle pulses with registered data
	always @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			boot_done    <= 1'b0;
			o_boot       <= 1'b0;
			o_entry      <= 1'b0;
			o_top_ack    <= 1'b0;
			o_chan_ack   <= 24'h000000;
			o_dma_grant  <= 24'h000000;
			o_fetch_addr <= `PIA_BOOT_ADDR;
			o_vector     <= 8'h00;
			o_push_seg   <= 1'b0;
			o_push_flags <= 1'b0;
			o_pop_seg    <= 1'b0;
		end else begin
			boot_done    <= 1'b1;
			o_boot       <= !boot_done;
			o_entry      <= tl_take || int_take || div_take;
			o_top_ack    <= tl_take;
			o_chan_ack   <= int_take ? (24'h000001 << win_idx) : 24'h000000;
			o_dma_grant  <= dma_take ? (24'h000001 << win_idx) : 24'h000000;
			o_push_seg   <= (tl_take || int_take) && seg_save;
			o_push_flags <= tl_take || int_take;
			o_pop_seg    <= i_iret && seg_save;
			// Fetch address follows the same priority as the takes
			if (!boot_done) begin
				o_fetch_addr <= `PIA_BOOT_ADDR;
			end else if (tl_take) begin
				o_fetch_addr <= {iseg, `PIA_TL_VEC_OFS};
			end else if (int_take) begin
				o_vector     <= {vbase_reg[pair], win_idx[0], 1'b0};
				o_fetch_addr <= {iseg, 8'h00, vbase_reg[pair], win_idx[0], 1'b0};
			end else if (div_take) begin
				o_fetch_addr <= {o_code_seg, `PIA_DIV_VEC_OFS};
			end
		end
	end

	// Read data one cycle after the strobe, zero otherwise
	always @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_reg_rdata <= 8'h00;
		end else if (!i_reg_read) begin
			o_reg_rdata <= 8'h00;
		end else begin
			case (i_reg_addr)
				`PIA_OFF_CTRL:     o_reg_rdata <= {tl_src_wdt, tl_unmaskable, mode_nested, global_irq_enable, 1'b0, current_priority_level};
				`PIA_OFF_EXT_EDGE: o_reg_rdata <= ext_rising;
				`PIA_OFF_EXTERNAL_MODE_REGISTER_TWO:     o_reg_rdata <= {7'h00, seg_save};
				`PIA_OFF_ISEG:     o_reg_rdata <= iseg;
				`PIA_OFF_CSEG:     o_reg_rdata <= cseg;
				`PIA_OFF_NEST:     o_reg_rdata <= nest_stack;
				// Pending byte 0 merges external latches with peripheral lines
				`PIA_OFF_PEND0:    o_reg_rdata <= int_req[7:0];
				`PIA_OFF_PEND1:    o_reg_rdata <= int_req[15:8];
				`PIA_OFF_PEND2:    o_reg_rdata <= int_req[23:16];
				`PIA_OFF_STATUS:   o_reg_rdata <= {5'h00, use_iseg, tl_req, tl_active};
				default: begin
					// Banks; anything else reads zero
					if (in_bank(i_reg_addr, `PIA_OFF_LVL_BASE)) begin
						o_reg_rdata <= {5'h00, level_reg[i_reg_addr[3:0]]};
					end else if (in_bank(i_reg_addr, `PIA_OFF_VEC_BASE)) begin
						o_reg_rdata <= {vbase_reg[i_reg_addr[3:0]], 2'h0};
					end else begin
						o_reg_rdata <= 8'h00;
					end
				end
			endcase
		end
	end

endmodule // pia_arbiter

/* File: dv/pia_src_model.sv */
// Request sources that hold each pending request until acknowledged
`timescale 1ns/100ps
module pia_src_model (
	// Clock and reset
	input  wire        i_clock,
	input  wire        i_rst_n,
	// Bench controls
	input  wire [23:0] i_set,
	input  wire        i_clr,
	// Arbiter side
	input  wire [23:0] i_ack,
	output reg  [23:0] o_req
);
	// Only the acknowledged source drops, or all on i_clr; the others keep waiting
	always @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n)
			o_req <= 24'h000000;
		else
			o_req <= i_clr ? 24'h000000 : (o_req | i_set) & ~i_ack;
	end
endmodule // pia_src_model

/* File: dv/pia_arbiter_chk.sv */
// Concurrent checks on the arbiter ports
`timescale 1ns/100ps
module pia_arbiter_chk (
	// Clock and reset
	input wire        i_clock,
	input wire        i_rst_n,
	// Sequencer inputs
	input wire        i_arb_strobe,
	input wire        i_div_zero,
	input wire        i_iret,
	// Outputs under watch
	input wire [23:0] o_chan_ack,
	input wire [23:0] o_dma_grant,
	input wire        o_top_ack,
	input wire        o_boot,
	input wire        o_entry,
	input wire [23:0] o_fetch_addr,
	input wire [7:0]  o_vector,
	input wire        o_push_flags,
	input wire        o_pop_seg
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	ack_onehot_a: assert property ($onehot0(o_chan_ack))
		else $error("more than one channel acknowledged");
	ack_cause_a: assert property (|o_chan_ack |-> $past(i_arb_strobe))
		else $error("acknowledge without arbitration");
	ack_entry_a: assert property (|o_chan_ack |-> o_entry && o_push_flags && !o_top_ack)
		else $error("channel acknowledge without full entry");
	ack_pulse_a: assert property (|o_chan_ack |=> o_chan_ack == 24'h000000)
		else $error("second acknowledge with enable cleared");
	top_vector_a: assert property (o_top_ack |-> o_entry && o_fetch_addr[15:0] == 16'h0004)
		else $error("top level fetch address wrong");
	trap_fetch_a: assert property (o_entry && !o_top_ack && o_chan_ack == 24'h000000
		|-> $past(i_div_zero) && !o_push_flags && o_fetch_addr[15:0] == 16'h0002)
		else $error("trap entry wrong");
	boot_once_a: assert property (o_boot |-> o_fetch_addr == 24'h000000 ##1 !o_boot)
		else $error("boot fetch wrong");
	chan_vector_a: assert property (|o_chan_ack |-> o_fetch_addr[15:0] == {8'h00, o_vector}
		&& o_vector[0] == 1'b0 && o_vector[1] == |(o_chan_ack & 24'haaaaaa))
		else $error("channel vector wrong");
	pop_cause_a: assert property (o_pop_seg |-> $past(i_iret))
		else $error("segment pop without return");
	dma_cause_a: assert property (|o_dma_grant |-> $past(i_arb_strobe) && $onehot(o_dma_grant))
		else $error("transfer grant wrong");
endmodule // pia_arbiter_chk

bind pia_arbiter pia_arbiter_chk chk (.i_clock, .i_rst_n, .i_arb_strobe, .i_div_zero, .i_iret, .o_chan_ack,
	.o_dma_grant, .o_top_ack, .o_boot, .o_entry, .o_fetch_addr, .o_vector, .o_push_flags, .o_pop_seg);

/* File: dv/tb_priority_interrupt_arbiter.sv */
// Self-checking bench for the priority interrupt arbiter
`timescale 1ns/100ps
module tb_priority_interrupt_arbiter;
	logic        i_clock, i_rst_n, i_reg_write, i_reg_read, i_nmi_pin, i_wdt_top, i_arb_strobe;
	logic        i_div_zero, i_iret, src_clr, o_top_ack, o_boot, o_entry, o_push_seg, o_push_flags;
	logic        o_pop_seg, o_use_iseg;
	logic [7:0]  i_reg_addr, i_reg_wdata, i_ext_pin, i_popped_seg, o_reg_rdata, o_vector, o_code_seg, iseg;
	logic [23:0] i_chan_req, i_chan_dma, src_set, o_chan_ack, o_dma_grant, o_fetch_addr;
	logic [2:0]  lvl [12];  // Pair levels mirrored for expectations
	logic [7:0]  vb [12];   // Pair vector bases
	int          wk;        // Expected winner index
	int          bad_count = 0;
	int          comparisons = 0;

	pia_arbiter uut (.i_clock, .i_rst_n, .i_reg_addr, .i_reg_wdata, .i_reg_write, .i_reg_read, .o_reg_rdata,
		.i_chan_req, .i_chan_dma, .i_ext_pin, .i_nmi_pin, .i_wdt_top, .i_arb_strobe, .i_div_zero, .i_iret,
		.i_popped_seg, .o_chan_ack, .o_dma_grant, .o_top_ack, .o_boot, .o_entry, .o_fetch_addr, .o_vector,
		.o_push_seg, .o_push_flags, .o_pop_seg, .o_use_iseg, .o_code_seg);
	pia_src_model src (.i_clock, .i_rst_n, .i_set(src_set), .i_clr(src_clr), .i_ack(o_chan_ack), .o_req(i_chan_req));

	// Free running 50 MHz clock
	initial begin
		i_clock = 1'b0;
		forever #10 i_clock = ~i_clock;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// One-cycle write strobe; a gap cycle avoids double assignment
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clock);
		{i_reg_addr, i_reg_wdata, i_reg_write} <= {a, d, 1'b1};
		@(posedge i_clock);
		i_reg_write <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge i_clock);
		{i_reg_addr, i_reg_read} <= {a, 1'b1};
		@(posedge i_clock);
		i_reg_read <= 1'b0;
		#1 chk(o_reg_rdata, e);
	endtask

	// Sequencer pulse {iret, divide trap, arbitration}; outputs settle after
	task automatic step(input logic [2:0] s);
		@(posedge i_clock);
		{i_iret, i_div_zero, i_arb_strobe} <= s;
		@(posedge i_clock);
		{i_iret, i_div_zero, i_arb_strobe} <= 3'b000;
		#1;
	endtask

	task automatic srcs(input logic c, input logic [23:0] m);
		@(posedge i_clock);
		{src_clr, src_set} <= {c, m};
		@(posedge i_clock);
		{src_clr, src_set} <= 25'h0;
	endtask

	// Least level wins, ties to lowest channel, strictly below current
	function automatic logic [23:0] win(input logic [23:0] r, input logic [2:0] current_priority_level);
		logic [2:0] best;
		best = 3'h7;
		wk = -1;
		for (int c = 0; c < 24; c++)
			if (r[c] && (wk < 0 || lvl[c / 2] < best)) begin
				best = lvl[c / 2];
				wk = c;
			end
		return (wk >= 0 && best < current_priority_level) ? 24'h000001 << wk : 24'h000000;
	endfunction

	// Hang guard
	initial begin
		#400000;
		bad_count++;
		conclude();
	end

	initial begin
		logic [23:0] m;
		logic [23:0] e;
		logic [2:0]  current_priority_level;
		{i_rst_n, i_reg_write, i_reg_read, i_nmi_pin, i_wdt_top, i_arb_strobe, i_div_zero, i_iret, src_clr} = 9'h0;
		{i_reg_addr, i_reg_wdata, i_ext_pin, i_popped_seg, i_chan_dma, src_set} = 80'h0;
		void'($urandom(45));
		repeat (4) @(posedge i_clock);
		i_rst_n <= 1'b1;
		@(posedge i_clock);
		#1 chk({o_boot, o_fetch_addr}, {1'b1, 24'h000000});
		rd(8'he6, 8'h07);
		rd(8'hf3, 8'h07);
		rd(8'h10, 8'h00);
		$display("reset test done");
		// Transfer grant needs no enable
		i_chan_dma <= 24'h000020;
		step(3'b001);
		chk(o_dma_grant, 24'h000020);
		i_chan_dma <= 24'h000000;
		// Nested entry with segment save, odd channel of pair 1
		wr(8'he9, 8'h3c);
		wr(8'he8, 8'h01);
		wr(8'hf1, 8'h03);
		wr(8'hd1, 8'h40);
		srcs(1'b0, 24'h000008);
		wr(8'he6, 8'h35);
		step(3'b001);
		chk({o_push_seg, o_push_flags, o_chan_ack}, {2'b11, 24'h000008});
		chk(o_fetch_addr, 24'h3c0042);
		rd(8'he6, 8'h23);
		rd(8'heb, 8'h20);
		chk(o_code_seg, 8'h3c);
		i_popped_seg <= 8'h5a;
		step(3'b100);
		chk(o_pop_seg, 1'b1);
		rd(8'he6, 8'h35);
		rd(8'heb, 8'h00);
		chk(o_code_seg, 8'h5a);
		// Compatible mode: interrupt segment stands in, priority kept
		wr(8'he8, 8'h00);
		srcs(1'b0, 24'h000008);
		wr(8'he6, 8'h15);
		step(3'b001);
		chk({o_push_seg, o_use_iseg, o_code_seg}, {2'b01, 8'h3c});
		rd(8'he6, 8'h05);
		step(3'b100);
		chk(o_use_iseg, 1'b0);
		$display("entry test done");
		// Top level beats a level 0 channel and cannot be interrupted
		wr(8'hf0, 8'h00);
		srcs(1'b1, 24'h000000);
		srcs(1'b0, 24'h000001);
		wr(8'he6, 8'h17);
		i_nmi_pin <= 1'b1;
		step(3'b001);
		chk({o_top_ack, o_chan_ack, 7'h00}, {1'b1, 31'h0});
		chk(o_fetch_addr, 24'h3c0004);
		i_nmi_pin <= 1'b0;
		wr(8'he6, 8'h17);
		step(3'b001);
		chk(o_chan_ack, 24'h000000);
		step(3'b100);
		step(3'b001);
		chk(o_chan_ack, 24'h000001);
		// Unmaskable top level from the watchdog, pin ignored
		wr(8'he6, 8'hc7);
		i_nmi_pin <= 1'b1;
		step(3'b001);
		chk(o_top_ack, 1'b0);
		{i_nmi_pin, i_wdt_top} <= 2'b01;
		step(3'b001);
		chk(o_top_ack, 1'b1);
		i_wdt_top <= 1'b0;
		step(3'b100);
		// Divide trap uses the code segment, no flags pushed
		wr(8'hea, 8'h77);
		step(3'b010);
		chk({o_entry, o_push_flags, o_fetch_addr}, {2'b10, 24'h770002});
		// External rising edge on input 0
		wr(8'he7, 8'h01);
		srcs(1'b1, 24'h000000);
		wr(8'he6, 8'h17);
		i_ext_pin <= 8'h01;
		repeat (3) @(posedge i_clock);
		step(3'b001);
		chk(o_chan_ack, 24'h000001);
		$display("top trap external test done");
		// Random levels, bases, requests and current priority
		iseg = 8'($urandom);
		wr(8'he9, iseg);
		for (int n = 0; n < 30; n++) begin
			for (int p = 0; p < 12; p++) begin
				{lvl[p], vb[p]} = 11'($urandom);
				// Keep channel vectors off the reserved words, which hold all ones
				if (vb[p] < 8'h08)
					vb[p] = vb[p] | 8'h08;
				wr(8'hf0 + 8'(p), {5'h00, lvl[p]});
				wr(8'hd0 + 8'(p), vb[p]);
			end
			m = (n == 0) ? 24'h00000c : (n == 1) ? 24'hffffff : 24'($urandom);
			current_priority_level = 3'($urandom);
			srcs(1'b1, 24'h000000);
			srcs(1'b0, m);
			wr(8'he6, {4'h1, 1'b0, current_priority_level});
			e = win(m, current_priority_level);
			step(3'b001);
			chk(o_chan_ack, e);
			if (e != 24'h000000) begin
				chk(o_fetch_addr, {iseg, 8'h00, vb[wk / 2][7:2], wk[0], 1'b0});
				chk(o_vector, {vb[wk / 2][7:2], wk[0], 1'b0});
			end
			rd(8'he6, {3'b000, ~|e, 1'b0, current_priority_level});
		end
		$display("random test done");
		conclude();
	end
endmodule // tb_priority_interrupt_arbiter
